// ### verif/fpbr_fpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpbr_fpu_model #(
    parameter int FPR_W = 64
) (
    input  wire logic             clk,
    input  wire logic [4:0]       fprRdIdx,
    output logic      [FPR_W-1:0] fprRdData,
    output logic                  fprRdPending
);
    logic [FPR_W-1:0] noise = '0;
    logic [2:0]       cyc   = '0;
    // upper bits churn every cycle so only bit zero may steer a branch
    always_ff @(posedge clk) begin
        noise <= {noise[FPR_W-2:0], ~noise[FPR_W-1]};
        cyc   <= cyc + 3'h1;
    end
    // an outstanding register write stalls one cycle in eight
    assign fprRdPending = cyc == 3'h5;
    assign fprRdData = {noise[FPR_W-1:1], fprRdIdx[0] ^ fprRdIdx[2]};
endmodule // fpbr_fpu_model
`default_nettype wire

// ### verif/fpbr_resolver_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "fpbr_cfg.svh"
module fpbr_chk
    import fpbr_pkg::*;
#(
    parameter int PC_W  = 32,
    parameter int FPR_W = 64
) (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 ce,
    input wire logic                 newestRelease,
    input wire logic                 fpuEnable,
    input wire logic                 unimplTrap,
    input wire logic                 ccPending,
    input wire logic                 fprRdPending,
    input wire logic                 predUpdateEn,
    input wire logic                 brValid,
    input wire fpbr_pkg::fpbr_op_e   brOp,
    input wire logic [PC_W-1:0]      brPc,
    input wire logic [15:0]          brOffset,
    input wire logic                 brReady,
    input wire logic [FPR_W-1:0]     fprRdData,
    input wire logic                 ccWrEn,
    input wire logic [2:0]           ccWrSel,
    input wire logic                 ccWrVal,
    input wire logic                 slotValid,
    input wire logic                 slotIsCti,
    input wire logic                 resValid,
    input wire logic                 resTaken,
    input wire logic [PC_W-1:0]      resTarget,
    input wire logic                 nullifyDelaySlot,
    input wire logic                 predictTaken,
    input wire logic                 excValid,
    input wire fpbr_pkg::fpbr_exc_e  excCause,
    input wire logic                 fcsrCondBit
);
    logic            acc, lik, leg, wait_r, likely_r, bitOp_r, bit_r, set_r, stale;
    logic [PC_W-1:0] tgt_r;
    assign acc = ce && brValid && brOp != FPBR_OP_NONE && brReady;
    assign lik = brOp == FPBR_OP_COND_FALSE_L || brOp == FPBR_OP_COND_TRUE_L;
    assign leg = brOp >= FPBR_OP_COND_FALSE;
    // a request whose tested value is still being produced
    assign stale = brValid && (leg ? ccPending : (brOp != FPBR_OP_NONE && fprRdPending));
    ////////////////////////////////////////////////////////////////////////////////
    // remember what the accepted branch must resolve to
    always_ff @(posedge clk) begin
        wait_r <= rst ? 1'b0 : acc ? 1'b1 : (slotValid || excValid) ? 1'b0 : wait_r;
        if (acc) begin
            tgt_r    <= brPc + PC_W'(4) + PC_W'($signed({brOffset, 2'b00}));
            likely_r <= lik;
            bitOp_r  <= !leg;
            bit_r    <= fprRdData[0];
            set_r    <= brOp == FPBR_OP_BIT_SET;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_acc; acc; endsequence
    sequence s_ctiSlot; wait_r && slotValid && slotIsCti && newestRelease && !excValid; endsequence
    sequence s_accOk; fpuEnable && !(leg && (newestRelease || unimplTrap)); endsequence
    AST_CPU: assert property (s_acc ##0 !fpuEnable |=>
        excValid && excCause == FPBR_EXC_CPU) else $error("no unusable exception");
    AST_LEG_NEW: assert property (s_acc ##0 (fpuEnable && newestRelease && leg) |=>
        excValid && excCause == FPBR_EXC_RESERVED) else $error("legacy not refused");
    AST_CTI: assert property (s_ctiSlot |=>
        excValid && excCause == FPBR_EXC_RESERVED) else $error("slot transfer not trapped");
    AST_LIKELY: assert property (s_acc ##0 s_accOk |=>
        predictTaken == $past(lik) && predUpdateEn == !$past(lik))
        else $error("likely prediction wrong");
    AST_TARGET: assert property (resValid && !excValid |->
        resTarget == tgt_r) else $error("bad target");
    AST_BIT: assert property (resValid && !excValid && bitOp_r |->
        resTaken == (set_r ~^ bit_r)) else $error("bit test wrong");
    AST_NULL: assert property (resValid && !excValid |->
        nullifyDelaySlot == (likely_r && !resTaken)) else $error("nullify wrong");
    AST_CC0: assert property (ce && ccWrEn && ccWrSel == 3'h0 |=>
        fcsrCondBit == $past(ccWrVal)) else $error("status bit not code zero");
    AST_STALL: assert property (stale |-> !brReady)
        else $error("branch accepted on stale value");
endmodule // fpbr_chk
`default_nettype wire

// ### verif/tb_fpbr_resolver.sv
`timescale 1ns/1ns
`default_nettype none
module tb_fpbr_resolver;
    import fpbr_pkg::*;
    typedef struct {logic e; fpbr_exc_e c; logic t; logic [31:0] g; logic n; logic p;} fpbr_exp_s;
    logic        clk = 0, rst = 1, brValid = 0, newestRelease = 0, fpuEnable = 1, unimplTrap = 0;
    logic        ccWrEn = 0, ccWrVal = 0, slotValid = 0, slotIsCti = 0, ce = 1, ccPend = 0;
    logic        predictTaken, cpCond;
    logic        fprRdPending, brReady, resValid, resTaken, nullifyDelaySlot, excValid, fcsrCondBit;
    logic [31:0] brPc = 0, resTarget;
    logic [15:0] brOffset = 0;
    logic [4:0]  idx = 0, fprRdIdx;
    logic [2:0]  ccSel = 0, ccWrSel = 0;
    logic [63:0] fprRdData;
    logic [7:0]  ccm = 0;
    fpbr_op_e    brOp = FPBR_OP_NONE;
    fpbr_exc_e   excCause;
    fpbr_exp_s   q[$], m;
    int          miscompares = 0, n_checks = 0;
    integer      seed = 76;
    fpbr_resolver DUT (.clk(clk), .rst(rst), .ce(ce), .newestRelease(newestRelease),
        .fpuEnable(fpuEnable), .unimplTrap(unimplTrap), .brValid(brValid), .brOp(brOp),
        .brPc(brPc), .brOffset(brOffset), .testedRegisterIndex(idx),
        .conditionCodeSelect(ccSel), .brReady(brReady), .fprRdIdx(fprRdIdx),
        .fprRdData(fprRdData), .fprRdPending(fprRdPending), .ccWrEn(ccWrEn),
        .ccWrSel(ccWrSel), .ccWrVal(ccWrVal), .ccPending(ccPend), .slotValid(slotValid),
        .slotIsCti(slotIsCti), .resValid(resValid), .resTaken(resTaken),
        .resTarget(resTarget), .nullifyDelaySlot(nullifyDelaySlot),
        .predictTaken(predictTaken), .predUpdateEn(), .excValid(excValid),
        .excCause(excCause), .coprocessorConditionSignal(cpCond),
        .fcsrCondBit(fcsrCondBit));
    fpbr_fpu_model u_fpu (.clk(clk), .fprRdIdx(fprRdIdx), .fprRdData(fprRdData),
        .fprRdPending(fprRdPending));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one branch with random setup, its note queued before it is sent
    task automatic branch(fpbr_op_e op);
        fpbr_exp_s   e;
        logic [31:0] pc;
        logic [15:0] off;
        logic [4:0]  ix;
        logic [2:0]  cs, ws;
        logic        wv, fe, nr, ut, cti, leg;
        pc = 32'($random(seed)) & 32'hffff_fffc;
        off = 16'($random(seed));
        ix = 5'($random(seed));
        cs = 3'($random(seed));
        ws = 3'($random(seed));
        wv = 1'($random(seed));
        fe = ($random(seed) & 7) != 0;
        nr = 1'($random(seed));
        ut = ($random(seed) & 7) == 0;
        cti = nr && ($random(seed) & 3) == 0;
        leg = op >= FPBR_OP_COND_FALSE;
        ccm[ws] = wv;
        e.t = leg ? ccm[cs] == (op >= FPBR_OP_COND_TRUE) : ix[0] ^ ix[2] ^ (op == FPBR_OP_BIT_CLEAR);
        e.e = !fe || (leg && (nr || ut)) || cti;
        e.c = !fe ? FPBR_EXC_CPU : ((leg && nr) || cti) ? FPBR_EXC_RESERVED : FPBR_EXC_UNIMPL;
        e.p = (op == FPBR_OP_COND_FALSE_L || op == FPBR_OP_COND_TRUE_L);
        e.n = e.p && !e.t;
        e.g = pc + 32'h4 + {{14{off[15]}}, off, 2'b00};
        q.push_back(e);
        @(posedge clk);
        brValid  <= 1'b1;
        brOp     <= op;
        brPc     <= pc;
        brOffset <= off;
        idx      <= ix;
        ccSel    <= cs;
        {ccWrEn, ccWrSel, ccWrVal, fpuEnable, newestRelease, unimplTrap} <= {1'b1, ws, wv, fe, nr, ut};
        repeat (20) begin
            @(negedge clk);
            if (brReady === 1'b1) break;
        end
        if (brReady !== 1'b1) begin
            miscompares++;
            end_of_test();
        end
        @(posedge clk);
        {brValid, ccWrEn, slotValid, slotIsCti} <= {1'b0, 1'b0, 1'b1, cti};
        @(posedge clk);
        slotValid <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clk = ~clk;
    end
    // a compare in flight one cycle in eight stalls legacy branches
    always @(posedge clk) begin
        ccPend <= ($random(seed) & 7) == 3;
    end
    // take the oldest note whenever a resolution shows
    always @(negedge clk) begin
        if (!rst && (resValid === 1'b1 || excValid === 1'b1)) begin
            chk("note waiting", q.size() != 0, 1);
            chk("code zero out", {cpCond, fcsrCondBit}, {2{ccm[0]}});
            if (q.size() != 0) begin
                m = q.pop_front();
                chk("exception", excValid, m.e);
                if (m.e) begin
                    chk("cause", excCause, m.c);
                end else begin
                    chk("taken", resTaken, m.t);
                    chk("target", resTarget, m.g);
                    chk("nullify", nullifyDelaySlot, m.n);
                    chk("predict", predictTaken, m.p);
                end
            end
        end
    end
    // reset, then every operation many times with random codes and setup
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 150; i++) branch(fpbr_op_e'(3'(1 + i % 6)));
        // freeze: a compare and a trapping branch under ce low leave no trace
        @(posedge clk);
        ce        <= 1'b0;
        brValid   <= 1'b1;
        brOp      <= FPBR_OP_BIT_SET;
        fpuEnable <= 1'b0;
        ccWrEn    <= 1'b1;
        ccWrSel   <= 3'h0;
        ccWrVal   <= !ccm[0];
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("frozen code", fcsrCondBit, ccm[0]);
        chk("frozen exception", excValid, 0);
        @(posedge clk);
        ce        <= 1'b1;
        brValid   <= 1'b0;
        ccWrEn    <= 1'b0;
        fpuEnable <= 1'b1;
        // second reset in mid-run, then more branches
        @(posedge clk);
        rst <= 1'b1;
        ccm = '0;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset outputs", {cpCond, predictTaken, resValid, excValid}, 0);
        for (int i = 0; i < 12; i++) branch(fpbr_op_e'(3'(1 + i % 6)));
        repeat (4) @(posedge clk);
        chk("notes left", q.size(), 0);
        end_of_test();
    end
endmodule // tb_fpbr_resolver
// checker watches the resolver ports from outside the bench module
bind fpbr_resolver fpbr_chk #(.PC_W(PC_W), .FPR_W(FPR_W)) u_chk (.*);
`default_nettype wire

// ### verilog/fpbr_cc_file.sv
`timescale 1ns/1ns
`default_nettype none
`include "fpbr_cfg.svh"
// eight condition codes with compare write-through forwarding
module fpbr_cc_file (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       ccWrEn,
    input  wire logic [`FPBR_CC_SEL_W-1:0]  ccWrSel,
    input  wire logic                       ccWrVal,
    input  wire logic [`FPBR_CC_SEL_W-1:0]  ccRdSel,
    output logic                            ccRdVal,
    output logic [`FPBR_NUM_CC-1:0]         ccAll
);
    logic [`FPBR_NUM_CC-1:0] cc_r;
    logic [`FPBR_NUM_CC-1:0] cc_nxt;
    // compare writes the named code only
    always_comb begin
        cc_nxt = cc_r;
        if (ccWrEn) begin
            cc_nxt[ccWrSel] = ccWrVal; // [RULE9]
        end
    end
    // register the codes
    always_ff @(posedge clk) begin
        if (rst) begin
            cc_r <= `FPBR_CC_RESET;
        end else if (ce) begin
            cc_r <= cc_nxt;
        end
    end
    // a same-cycle compare is forwarded to the reader
    assign ccRdVal = cc_nxt[ccRdSel]; // [RULE18]
    assign ccAll   = cc_r;
endmodule // fpbr_cc_file
`default_nettype wire

// ### verilog/fpbr_cfg.svh
`ifndef FPBR_CFG_SVH
`define FPBR_CFG_SVH
// branch offset and target arithmetic
`define FPBR_OFFSET_W      16
`define FPBR_SHIFT         2
`define FPBR_TEXT_W        18
`define FPBR_PC_STEP       32'h0000_0004
// condition code file
`define FPBR_NUM_CC        8
`define FPBR_CC_SEL_W      3
`define FPBR_CC_RESET      8'h00
`define FPBR_CC_FCSR_IDX   3'h0
// tested bit of a floating-point register
`define FPBR_FPR_TEST_BIT  0
// register index width
`define FPBR_FPR_IDX_W     5
`endif

// ### verilog/fpbr_pkg.sv
package fpbr_pkg;
    // branch operation presented with a request
    typedef enum logic [2:0] {
        FPBR_OP_NONE        = 3'h0,
        FPBR_OP_BIT_CLEAR   = 3'h1,
        FPBR_OP_BIT_SET     = 3'h2,
        FPBR_OP_COND_FALSE  = 3'h3,
        FPBR_OP_COND_FALSE_L = 3'h4,
        FPBR_OP_COND_TRUE   = 3'h5,
        FPBR_OP_COND_TRUE_L = 3'h6
    } fpbr_op_e;
    // resolver state, gray along idle -> wait -> idle
    typedef enum logic [1:0] {
        FPBR_ST_IDLE = 2'b00,
        FPBR_ST_WAIT = 2'b01,
        FPBR_ST_SLOT = 2'b11
    } fpbr_state_e;
    // exception cause reported with a resolution
    typedef enum logic [1:0] {
        FPBR_EXC_NONE     = 2'h0,
        FPBR_EXC_CPU      = 2'h1,
        FPBR_EXC_RESERVED = 2'h2,
        FPBR_EXC_UNIMPL   = 2'h3
    } fpbr_exc_e;
endpackage

// ### verilog/fpbr_resolver.sv
// Functional notes
// [RULE1] bit-test branches examine register bit zero
// [RULE2] register width and format never matter
// [RULE3] target is next pc plus shifted offset
// [RULE4] false branch taken on code zero
// [RULE5] true branch taken on code one
// [RULE6] false-likely nullifies slot when not taken
// [RULE7] code select picks one of eight
// [RULE8] short form tests condition code zero
// [RULE9] code holds latest compare result
// [RULE10] legacy branches raise unusable, reserved, unimplemented
// [RULE11] newest release rejects legacy code branches
// [RULE12] software keeps control transfers out of slots
// [RULE13] likely forms predicted taken, tables untouched
// [RULE14] code zero is the status bit
// [RULE15] bit-test branches execute slot first
// [RULE16] disabled coprocessor raises unusable exception
// [RULE17] newest release traps transfers in slot
// [RULE18] forward or stall for fresh compare
`timescale 1ns/1ns
`default_nettype none
`include "fpbr_cfg.svh"
module fpbr_resolver
    import fpbr_pkg::*;
#(
    parameter int PC_W  = 32,
    parameter int FPR_W = 64
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // configuration
    input  wire logic                        newestRelease,
    input  wire logic                        fpuEnable,
    input  wire logic                        unimplTrap,
    // branch request from decode
    input  wire logic                        brValid,
    input  wire fpbr_pkg::fpbr_op_e          brOp,
    input  wire logic [PC_W-1:0]             brPc,
    input  wire logic [`FPBR_OFFSET_W-1:0]   brOffset,
    input  wire logic [`FPBR_FPR_IDX_W-1:0]  testedRegisterIndex,
    input  wire logic [`FPBR_CC_SEL_W-1:0]   conditionCodeSelect,
    output logic                             brReady,
    // register file read port and pending write scoreboard
    output logic [`FPBR_FPR_IDX_W-1:0]       fprRdIdx,
    input  wire logic [FPR_W-1:0]            fprRdData,
    input  wire logic                        fprRdPending,
    // compare result writing a condition code
    input  wire logic                        ccWrEn,
    input  wire logic [`FPBR_CC_SEL_W-1:0]   ccWrSel,
    input  wire logic                        ccWrVal,
    input  wire logic                        ccPending,
    // slot instruction information
    input  wire logic                        slotValid,
    input  wire logic                        slotIsCti,
    // resolution to fetch
    output logic                             resValid,
    output logic                             resTaken,
    output logic [PC_W-1:0]                  resTarget,
    output logic                             nullifyDelaySlot,
    output logic                             predictTaken,
    output logic                             predUpdateEn,
    output logic                             excValid,
    output fpbr_pkg::fpbr_exc_e              excCause,
    output logic                             coprocessorConditionSignal,
    output logic                             fcsrCondBit
);
    import fpbr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        fpbr_state_e          st;
        logic                 taken;
        logic                 nullify;
        logic [PC_W-1:0]      target;
        logic                 resValid;
        logic                 resTaken;
        logic [PC_W-1:0]      resTarget;
        logic                 nullify2;
        logic                 predTaken;
        logic                 predUpd;
        logic                 excValid;
        fpbr_exc_e            exc;
    } fpbr_state_s;

    fpbr_state_s s_r;
    fpbr_state_s s_nxt;

    logic                    ccVal;
    logic [`FPBR_NUM_CC-1:0] ccAll;
    logic [PC_W-1:0]         target;
    logic [`FPBR_CC_SEL_W-1:0] ccSel;

    // classify operations
    function automatic logic isLegacy(input fpbr_op_e op);
        return (op == FPBR_OP_COND_FALSE) || (op == FPBR_OP_COND_FALSE_L) ||
               (op == FPBR_OP_COND_TRUE) || (op == FPBR_OP_COND_TRUE_L);
    endfunction

    function automatic logic isLikely(input fpbr_op_e op);
        return (op == FPBR_OP_COND_FALSE_L) || (op == FPBR_OP_COND_TRUE_L);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // submodules
    assign ccSel = conditionCodeSelect; // [RULE7] [RULE8]

    fpbr_cc_file u_cc (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .ccWrEn  (ccWrEn),
        .ccWrSel (ccWrSel),
        .ccWrVal (ccWrVal),
        .ccRdSel (ccSel),
        .ccRdVal (ccVal),
        .ccAll   (ccAll)
    );

    fpbr_target #(
        .PC_W (PC_W)
    ) u_tgt (
        .branchPc    (brPc),
        .offsetField (brOffset),
        .targetPc    (target)
    );

    assign fprRdIdx = testedRegisterIndex;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic cond;
        logic isBit;
        logic stall;
        cond  = 1'b0;
        isBit = (brOp == FPBR_OP_BIT_CLEAR) || (brOp == FPBR_OP_BIT_SET);
        // hold off while the tested value is still in flight
        stall = (isBit && fprRdPending) || (isLegacy(brOp) && ccPending); // [RULE18]
        s_nxt = s_r;
        s_nxt.resValid = 1'b0;
        s_nxt.excValid = 1'b0;
        s_nxt.predUpd  = 1'b0;
        case (brOp)
            FPBR_OP_BIT_CLEAR:    cond = ~fprRdData[`FPBR_FPR_TEST_BIT]; // [RULE1] [RULE2]
            FPBR_OP_BIT_SET:      cond = fprRdData[`FPBR_FPR_TEST_BIT]; // [RULE1] [RULE2]
            FPBR_OP_COND_FALSE,
            FPBR_OP_COND_FALSE_L: cond = ~ccVal; // [RULE4] [RULE6]
            FPBR_OP_COND_TRUE,
            FPBR_OP_COND_TRUE_L:  cond = ccVal; // [RULE5]
            default:              cond = 1'b0;
        endcase
        case (s_r.st)
            FPBR_ST_IDLE: begin
                if (brValid && brOp != FPBR_OP_NONE && !stall) begin
                    if (!fpuEnable) begin
                        s_nxt.excValid = 1'b1;
                        s_nxt.exc      = FPBR_EXC_CPU; // [RULE16] [RULE10]
                    end else if (isLegacy(brOp) && newestRelease) begin
                        s_nxt.excValid = 1'b1;
                        s_nxt.exc      = FPBR_EXC_RESERVED; // [RULE11] [RULE10]
                    end else if (isLegacy(brOp) && unimplTrap) begin
                        s_nxt.excValid = 1'b1;
                        s_nxt.exc      = FPBR_EXC_UNIMPL; // [RULE10]
                    end else begin
                        s_nxt.st        = FPBR_ST_WAIT;
                        s_nxt.taken     = cond;
                        s_nxt.target    = target;
                        // likely forms drop the slot when not taken
                        s_nxt.nullify   = isLikely(brOp) && !cond; // [RULE6]
                        s_nxt.predTaken = isLikely(brOp); // [RULE13]
                        s_nxt.predUpd   = !isLikely(brOp); // [RULE13]
                    end
                end
            end
            FPBR_ST_WAIT: begin
                // redirect only once the slot instruction is seen
                if (slotValid) begin
                    s_nxt.st = FPBR_ST_IDLE;
                    if (slotIsCti && newestRelease) begin
                        s_nxt.excValid = 1'b1;
                        s_nxt.exc      = FPBR_EXC_RESERVED; // [RULE17]
                    end else begin
                        s_nxt.resValid  = 1'b1;
                        s_nxt.resTaken  = s_r.taken; // [RULE15] [RULE4] [RULE5]
                        s_nxt.resTarget = s_r.target;
                        s_nxt.nullify2  = s_r.nullify;
                    end
                end
            end
            default: begin
                s_nxt.st = FPBR_ST_IDLE;
            end
        endcase
    end

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign brReady          = (s_r.st == FPBR_ST_IDLE) && !(
                              ((brOp == FPBR_OP_BIT_CLEAR || brOp == FPBR_OP_BIT_SET)
                               && fprRdPending) || (isLegacy(brOp) && ccPending));
    assign resValid         = s_r.resValid;
    assign resTaken         = s_r.resTaken;
    assign resTarget        = s_r.resTarget;
    assign nullifyDelaySlot = s_r.nullify2;
    assign predictTaken     = s_r.predTaken;
    assign predUpdateEn     = s_r.predUpd;
    assign excValid         = s_r.excValid;
    assign excCause         = s_r.exc;
    // code zero doubles as the status register condition bit
    assign coprocessorConditionSignal = ccAll[`FPBR_CC_FCSR_IDX]; // [RULE14]
    assign fcsrCondBit      = ccAll[`FPBR_CC_FCSR_IDX]; // [RULE14]
endmodule // fpbr_resolver
`default_nettype wire

// ### verilog/fpbr_target.sv
`timescale 1ns/1ns
`default_nettype none
`include "fpbr_cfg.svh"
// pc-relative target: (pc + 4) + sign_extend(offset << 2)
module fpbr_target #(
    parameter int PC_W = 32
) (
    input  wire logic [PC_W-1:0]            branchPc,
    input  wire logic [`FPBR_OFFSET_W-1:0]  offsetField,
    output logic      [PC_W-1:0]            targetPc
);
    logic [`FPBR_TEXT_W-1:0] shifted;
    logic [PC_W-1:0]         extended;
    // shift then sign extend the 18-bit result
    always_comb begin
        shifted  = {offsetField, {`FPBR_SHIFT{1'b0}}};
        extended = {{(PC_W-`FPBR_TEXT_W){shifted[`FPBR_TEXT_W-1]}}, shifted};
        targetPc = branchPc + PC_W'(`FPBR_PC_STEP) + extended; // [RULE3]
    end
endmodule // fpbr_target
`default_nettype wire
